// >>> rtl/euart_pkg.sv
// Purpose: Shared constants of the serial port interrupt and baud logic
// Assumes: APB with 32-bit data, register index times four is byte address
// Notes: Indices are word indices on the bus
package euart_pkg;
  localparam int ADDR_W = 18;
  localparam int IDX_FLAGS = 32'ha0a0;
  localparam int IDX_BAUD_HI = 32'ha0a1;
  localparam int IDX_STATUS = 32'ha0a2;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = ADDR_W'(IDX_FLAGS * 4);
  localparam logic [ADDR_W-1:0] ADDR_BAUD_HI = ADDR_W'(IDX_BAUD_HI * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
  // Bit positions in the flag and status words
  localparam int BIT_TXDONE = 0;
  localparam int BIT_FRAME = 1;
  localparam int BIT_TXOVF = 2;
  localparam int BIT_RXUNF = 3;
  localparam int BIT_GLOBAL = 7;
  localparam logic [7:0] BAUD_HI_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
endpackage

// >>> rtl/sticky_flag.sv
// Purpose: One event flag with its interrupt enable
// Assumes: All inputs are on ref_clk
// Notes: A set in the same cycle as any clear wins
`timescale 1ns/10ps
module sticky_flag
  import euart_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Event and clears
  input wire logic setEvt,
  input wire logic ctlWrite,
  input wire logic ctlBit,
  input wire logic statusClr,
  input wire logic hwClr,
  // State
  output logic flag,
  output logic enable
);
  logic flag_reg;
  logic flag_next;
  logic en_reg;
  logic en_next;

  always_comb
  begin
    flag_next = flag_reg;
    en_next = en_reg;
    if (ctlWrite)
    begin
      en_next = ctlBit;
      if (!ctlBit)
        flag_next = 1'b0;
    end
    if (statusClr || hwClr)
      flag_next = 1'b0;
    // Set beats clear so no event is lost
    if (setEvt)
      flag_next = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flag_reg <= FLAG_RESET;
      en_reg <= FLAG_RESET;
    end
    else
    begin
      flag_reg <= flag_next;
      en_reg <= en_next;
    end
  end

  assign flag = flag_reg;
  assign enable = en_reg;
endmodule

// >>> rtl/euart_int_flags_baud.sv
// Purpose: Interrupt flags, enables and baud divisor high byte over APB
// Assumes: FIFO and shifter events come from logic on ref_clk
// Notes: One wait state on every APB access
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module euart_int_flags_baud
  import euart_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [euart_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // FIFO and shifter events
  input wire logic rxFifoRead,
  input wire logic rxFifoEmpty,
  input wire logic rxFifoReset,
  input wire logic txFifoWrite,
  input wire logic txFifoFull,
  input wire logic txFifoReset,
  input wire logic txFifoEmpty,
  input wire logic txShiftDone,
  input wire logic rxByteDone,
  input wire logic rxStopBad,
  // Outputs to the port
  output logic [7:0] baudDivisorHigh,
  output logic irq
);
  import euart_pkg::*;

  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] baud_reg;
  logic [7:0] baud_next;
  logic gen_reg;
  logic gen_next;
  logic access;
  logic wrDone;
  logic hitFlags;
  logic hitBaud;
  logic hitStatus;
  logic mapped;
  logic ctlWrite;
  logic statusWrite;
  logic [3:0] setEvt;
  logic [3:0] hwClr;
  logic [3:0] flags;
  logic [3:0] enables;
  logic [7:0] flagByte;
  logic [7:0] statusByte;

  assign access = psel && penable;
  assign hitFlags = (paddr == ADDR_FLAGS);
  assign hitBaud = (paddr == ADDR_BAUD_HI);
  assign hitStatus = (paddr == ADDR_STATUS);
  assign mapped = hitFlags || hitBaud || hitStatus;
  assign pready = ack_reg;
  // Unmapped access answers with an error, writes dropped
  assign pslverr = ack_reg && !mapped;
  assign wrDone = access && ack_reg && pwrite;
  assign ctlWrite = wrDone && hitFlags;
  assign statusWrite = wrDone && hitStatus;

  // Event sources
  always_comb
  begin
    setEvt = 4'h0;
    hwClr = 4'h0;
    setEvt[BIT_TXDONE] = txShiftDone && txFifoEmpty;
    setEvt[BIT_FRAME] = rxByteDone && rxStopBad;
    setEvt[BIT_TXOVF] = txFifoWrite && txFifoFull;
    hwClr[BIT_TXOVF] = txFifoReset;
    setEvt[BIT_RXUNF] = rxFifoRead && rxFifoEmpty;
    hwClr[BIT_RXUNF] = rxFifoReset;
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_flag
    sticky_flag u_flag (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .setEvt(setEvt[i]),
      .ctlWrite(ctlWrite),
      .ctlBit(pwdata[i]),
      .statusClr(statusWrite && pwdata[i]),
      .hwClr(hwClr[i]),
      .flag(flags[i]),
      .enable(enables[i])
    );
  end

  assign flagByte = {gen_reg, 3'h0, flags};
  assign statusByte = {4'h0, flags};

  always_comb
  begin
    ack_next = access && !ack_reg;
    rdata_next = rdata_reg;
    baud_next = baud_reg;
    gen_next = gen_reg;
    // Read data captured in the first access cycle
    if (access && !ack_reg && !pwrite)
    begin
      rdata_next = 32'h0;
      if (hitFlags)
        rdata_next[7:0] = flagByte;
      else if (hitBaud)
        rdata_next[7:0] = baud_reg;
      else if (hitStatus)
        rdata_next[7:0] = statusByte;
    end
    if (wrDone && hitBaud)
      baud_next = pwdata[7:0];
    if (ctlWrite)
      gen_next = pwdata[BIT_GLOBAL];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
      baud_reg <= BAUD_HI_RESET;
      gen_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      baud_reg <= baud_next;
      gen_reg <= gen_next;
    end
  end

  assign prdata = rdata_reg;
  // zero divisor not guarded; software keeps it nonzero
  assign baudDivisorHigh = baud_reg;
  // Level interrupt, global enable gates all sources
  assign irq = gen_reg && |(flags & enables);

  a_tx_overflow_set:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    txFifoWrite && txFifoFull |=> flags[BIT_TXOVF])
  else $error("tx overflow flag not set");

  a_tx_overflow_reset:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    txFifoReset && !(txFifoWrite && txFifoFull) |=> !flags[BIT_TXOVF])
  else $error("tx overflow flag kept over FIFO reset");

  a_frame_err_set:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    rxByteDone && rxStopBad |=> flags[BIT_FRAME])
  else $error("framing flag not set");

  a_frame_en_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctlWrite && pwdata[BIT_FRAME] |=> enables[BIT_FRAME])
  else $error("framing enable not set");

  a_frame_zero_clear:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctlWrite && !pwdata[BIT_FRAME] && !setEvt[BIT_FRAME]
    |=> !flags[BIT_FRAME] && !enables[BIT_FRAME])
  else $error("framing zero write did not clear");

  a_frame_only_sw:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(flags[BIT_FRAME]) |-> $past(ctlWrite || statusWrite))
  else $error("framing flag cleared without software");

  a_tx_done_set:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    txShiftDone && txFifoEmpty |=> flags[BIT_TXDONE])
  else $error("tx complete flag not set");

  a_tx_done_ctl:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctlWrite && !setEvt[BIT_TXDONE]
    |=> enables[BIT_TXDONE] == $past(pwdata[BIT_TXDONE])
    && (flags[BIT_TXDONE] == ($past(pwdata[BIT_TXDONE])
    && $past(flags[BIT_TXDONE]))))
  else $error("tx complete control write wrong");

  a_baud_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDone && hitBaud |=> baudDivisorHigh == $past(pwdata[7:0]))
  else $error("divisor high byte not written");

  a_rx_underflow_set:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    rxFifoRead && rxFifoEmpty |=> flags[BIT_RXUNF])
  else $error("rx underflow flag not set");

  a_apb_one_wait:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    access && !pready |=> pready)
  else $error("APB answer late");

  a_tx_overflow_zero:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctlWrite && !pwdata[BIT_TXOVF] && !setEvt[BIT_TXOVF]
    |=> !flags[BIT_TXOVF] && !enables[BIT_TXOVF])
  else $error("tx overflow zero write did not clear");

  a_rx_underflow_zero:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctlWrite && !pwdata[BIT_RXUNF] && !setEvt[BIT_RXUNF]
    |=> !flags[BIT_RXUNF] && !enables[BIT_RXUNF])
  else $error("rx underflow zero write did not clear");

  a_tx_done_en:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctlWrite && pwdata[BIT_TXDONE] |=> enables[BIT_TXDONE])
  else $error("tx complete enable not set");

  a_frame_hold:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    flags[BIT_FRAME] && !ctlWrite && !statusWrite |=> flags[BIT_FRAME])
  else $error("framing flag lost without software");

  a_tx_done_hold:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    flags[BIT_TXDONE] && !ctlWrite && !statusWrite |=> flags[BIT_TXDONE])
  else $error("tx complete flag lost without software");

  a_tx_done_idle:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flags[BIT_TXDONE] && !(txShiftDone && txFifoEmpty)
    |=> !flags[BIT_TXDONE])
  else $error("tx complete flag set without event");

  a_frame_idle:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flags[BIT_FRAME] && !(rxByteDone && rxStopBad)
    |=> !flags[BIT_FRAME])
  else $error("framing flag set without event");

  a_tx_overflow_idle:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flags[BIT_TXOVF] && !(txFifoWrite && txFifoFull)
    |=> !flags[BIT_TXOVF])
  else $error("tx overflow flag set without event");

  a_rx_underflow_idle:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flags[BIT_RXUNF] && !(rxFifoRead && rxFifoEmpty)
    |=> !flags[BIT_RXUNF])
  else $error("rx underflow flag set without event");

  a_status_clear:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    statusWrite && setEvt == 4'h0 && hwClr == 4'h0
    |=> flags == ($past(flags) & ~$past(pwdata[3:0])))
  else $error("status write one did not clear");

  a_status_keeps_en:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    statusWrite |=> enables == $past(enables))
  else $error("status write changed enables");

  a_irq_gated:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !gen_reg |-> !irq)
  else $error("irq high with global enable off");

  a_irq_source:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq |-> (flags & enables) != 4'h0)
  else $error("irq high without enabled flag");

  a_irq_raise:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    gen_reg && (flags & enables) != 4'h0 |-> irq)
  else $error("irq low with enabled flag");

  a_baud_hold:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wrDone && hitBaud) |=> $stable(baudDivisorHigh))
  else $error("divisor high byte changed without write");

  a_apb_ack_pulse:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    pready |=> !pready)
  else $error("APB ready held too long");

  a_read_upper_zero:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    pready && !pwrite |-> prdata[31:8] == 24'h0)
  else $error("read data upper bits not zero");

  a_read_baud:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    access && !pready && !pwrite && hitBaud
    |=> prdata[7:0] == $past(baudDivisorHigh))
  else $error("divisor high byte read wrong");

  a_read_unmapped:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    access && !pready && !pwrite && !mapped
    |=> prdata == 32'h0)
  else $error("unmapped read not zero");
endmodule

// >>> testbench/event_source.sv
// Purpose: Stand-in for the FIFOs and shifters beside the flag logic
// Assumes: Bench changes evt just after a rising edge
// Notes: One code gives one cycle of one event
`timescale 1ns/10ps
module event_source
(
  // Command
  input wire logic [2:0] evt,
  // Events
  output logic rxFifoRead,
  output logic rxFifoEmpty,
  output logic rxFifoReset,
  output logic txFifoWrite,
  output logic txFifoFull,
  output logic txFifoReset,
  output logic txFifoEmpty,
  output logic txShiftDone,
  output logic rxByteDone,
  output logic rxStopBad
);
  assign txFifoWrite = (evt == 3'h1);
  assign txFifoFull = (evt == 3'h1);
  assign rxByteDone = (evt == 3'h2);
  assign rxStopBad = (evt == 3'h2);
  // last byte out; code 7 leaves data behind
  assign txShiftDone = (evt == 3'h3) || (evt == 3'h7);
  assign txFifoEmpty = (evt == 3'h3);
  assign rxFifoRead = (evt == 3'h4);
  assign rxFifoEmpty = (evt == 3'h4);
  assign txFifoReset = (evt == 3'h5);
  assign rxFifoReset = (evt == 3'h6);
endmodule

// >>> testbench/euart_int_flags_baud_test.sv
// Purpose: Self-checking bench for the flag logic and baud byte
// Assumes: One APB master, events from event_source
// Notes: Each flag is enabled, fired, masked and cleared
`timescale 1ns/10ps
module euart_int_flags_baud_test;
  import euart_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, irq;
  logic [7:0] baudDivisorHigh;
  logic [2:0] evt = 3'h0;
  logic rxFifoRead, rxFifoEmpty, rxFifoReset, txFifoWrite, txFifoFull;
  logic txFifoReset, txFifoEmpty, txShiftDone, rxByteDone, rxStopBad;
  int fails = 0, checked = 0;
  event_source partner (.evt, .rxFifoRead, .rxFifoEmpty, .rxFifoReset,
    .txFifoWrite, .txFifoFull, .txFifoReset, .txFifoEmpty, .txShiftDone,
    .rxByteDone, .rxStopBad);
  euart_int_flags_baud DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxFifoRead, .rxFifoEmpty,
    .rxFifoReset, .txFifoWrite, .txFifoFull, .txFifoReset, .txFifoEmpty,
    .txShiftDone, .rxByteDone, .rxStopBad, .baudDivisorHigh, .irq);
  always #12.5 ref_clk = ~ref_clk;
  task automatic end_sim;
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Read right after the edge, so values are those sampled by it
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, x, r, e);
    cmp(r, x);
  endtask
  task automatic fire(input logic [2:0] c);
    @(posedge ref_clk);
    evt <= c;
    @(posedge ref_clk);
    evt <= 3'h0;
    @(negedge ref_clk);
  endtask
  task automatic test_baud;
    logic [31:0] r;
    logic e;
    rd(ADDR_BAUD_HI, 32'h0);
    wr(ADDR_BAUD_HI, 32'ha5);
    rd(ADDR_BAUD_HI, 32'ha5);
    cmp({24'h0, baudDivisorHigh}, 32'ha5);
    apb(1'b0, ADDR_BAUD_HI, 32'h0, r, e);
    cmp({r[30:0], e}, 32'h14a);
    apb(1'b0, ADDR_STATUS + 18'h4, 32'h0, r, e);
    cmp({r[30:0], e}, 32'h1);
  endtask
  task automatic test_events;
    logic [2:0] code [4];
    logic [31:0] m;
    code = '{3'h3, 3'h2, 3'h1, 3'h4};
    for (int b = 0; b < 4; b++)
    begin
      m = 32'h1 << b;
      wr(ADDR_FLAGS, 32'h80 | m);
      fire(code[b]);
      cmp({31'h0, irq}, 32'h1);
      rd(ADDR_FLAGS, 32'h80 | m);
      wr(ADDR_FLAGS, 32'h80);
      rd(ADDR_FLAGS, 32'h80);
      fire(code[b]);
      cmp({31'h0, irq}, 32'h0);
      rd(ADDR_STATUS, m);
      wr(ADDR_STATUS, m);
      rd(ADDR_STATUS, 32'h0);
    end
    // Shift done with data left is no completion
    fire(3'h7);
    rd(ADDR_STATUS, 32'h0);
  endtask
  task automatic test_fifo_reset;
    fire(3'h1);
    fire(3'h4);
    fire(3'h5);
    rd(ADDR_STATUS, 32'h8);
    fire(3'h6);
    rd(ADDR_STATUS, 32'h0);
  endtask
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    cmp({31'h0, irq}, 32'h0);
    rd(ADDR_FLAGS, 32'h0);
    test_baud;
    test_events;
    test_fifo_reset;
    end_sim;
  end
endmodule
